/* File: run_command_defines.vh */
// Offsets, field positions and reset values of the run-command parameter bank
`ifndef RUN_COMMAND_DEFINES_VH
`define RUN_COMMAND_DEFINES_VH
`define ADDR_CONTROL_WRITE_GATE 8'h6d
`define ADDR_RUN_CONTROL        8'h6e
`define ADDR_TARGET_WRITE_GATE  8'h6f
`define ADDR_TARGET_POSITION    8'h70
`define RST_CONTROL_WRITE_GATE  8'h00
`define RST_RUN_CONTROL         16'h0000
`define RST_TARGET_WRITE_GATE   8'h00
`define RST_TARGET_POSITION     32'h00000000
`define BIT_RUN_UP      0
`define BIT_RUN_DOWN    1
`define BIT_TRANSFER    2
`define BIT_JOG_CONT    3
`define BIT_RELEASE     4
`define BIT_KEYS        5
`define BIT_NO_LOOP     6
`define BIT_REF_LOOP    7
`define BIT_JOG_UP      8
`define BIT_JOG_DOWN    9
`define BIT_READJUST    10
`define BIT_BRAKE_FREE  11
`define BIT_DRAG_CORR   12
`define BIT_CLEAR_ERR   14
`endif

/* File: param_read_mux.v */
// Registered read-data selector for the parameter bank
`timescale 1ns/10ps
`include "run_command_defines.vh"
module param_read_mux (
	input  wire        clock,
	input  wire        rstn,
	input  wire        rd_en,
	input  wire [7:0]  rd_index,
	input  wire [7:0]  control_write_gate,
	input  wire [15:0] run_control,
	input  wire [7:0]  target_write_gate,
	input  wire [31:0] target_position,
	output reg  [31:0] rd_data,
	output reg         rd_valid,
	output reg         rd_error
);
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_data  <= 32'h00000000;
			rd_valid <= 1'b0;
			rd_error <= 1'b0;
		end else begin
			rd_valid <= rd_en;
			rd_error <= 1'b0;
			if (rd_en) begin
				case (rd_index)
				`ADDR_CONTROL_WRITE_GATE: rd_data <= {24'h000000, control_write_gate};
				`ADDR_RUN_CONTROL:        rd_data <= {16'h0000, run_control};
				`ADDR_TARGET_WRITE_GATE:  rd_data <= {24'h000000, target_write_gate};
				`ADDR_TARGET_POSITION:    rd_data <= target_position;
				default: begin
					rd_data  <= 32'h00000000;
					rd_error <= 1'b1;
				end
				endcase
			end
		end
	end
endmodule

/* File: drive_run_command_registers.v */
// Run-command parameter bank: write gates, control word, target position and decoded run requests
`timescale 1ns/10ps
`include "run_command_defines.vh"
// Overview of operation
// - Control gate at zero: next control word write is dropped, word unchanged.
// - Target gate at zero: next target position write is dropped.
// - Bit 0 runs manually upward, bit 1 runs manually downward.
// - Process-data targets start positioning only while bit 2 is set.
// - Bit 3 allows continuous jog; cleared gives single jog steps only.
// - Axis driven only with bit 4, except key jog and bits 8/9 jog.
// - With bus connected, jog keys act only while bit 5 is set.
// - Bit 6 runs without approach loop; bit 7 runs initial reference loop.
// - Bit 8 jogs upward regardless of the release bit.
// - Bit 10 readjusts, bit 11 brakes free run, bit 12 drag error correction.
// - Target position is a signed 31-bit magnitude, default hundredths of mm.
module drive_run_command_registers (
	input  wire        clock,
	input  wire        rstn,
	input  wire        wr_en,
	input  wire        rd_en,
	input  wire [7:0]  index,
	input  wire [31:0] wr_data,
	input  wire        pd_target_valid,
	input  wire [31:0] pd_target,
	input  wire        bus_connected,
	input  wire        key_up,
	input  wire        key_down,
	input  wire [7:0]  error_events,
	output wire [31:0] rd_data,
	output wire        rd_valid,
	output wire        rd_error,
	output reg  [7:0]  error_status,
	output reg         run_up,
	output reg         run_down,
	output reg         jog_up,
	output reg         jog_down,
	output reg         jog_continuous,
	output reg         axis_drive_enable,
	output reg         position_start,
	output reg  [31:0] position_goal,
	output reg         no_approach_loop,
	output reg         reference_loop,
	output reg         readjust,
	output reg         brake_free_run,
	output reg         drag_correction
);
	reg  [7:0]  control_write_gate;
	reg  [15:0] run_control;
	reg  [7:0]  target_write_gate;
	reg  [31:0] target_position;
	reg         conn_meta;
	reg         conn_sync;
	reg  [1:0]  key_meta;
	reg  [1:0]  key_sync;
	wire        wr_ctl;
	wire        wr_tgt;
	wire        keys_ok;
	wire        key_jog;
	wire        ctl_gate_open;
	wire        tgt_gate_open;
	wire        pd_accept;
	reg  [7:0]  next_error_status;
	reg         next_run_up;
	reg         next_run_down;
	reg         next_jog_up;
	reg         next_jog_down;
	reg         next_jog_continuous;
	reg         next_axis_drive_enable;
	reg         next_position_start;
	reg  [31:0] next_position_goal;
	reg         next_no_approach_loop;
	reg         next_reference_loop;
	reg         next_readjust;
	reg         next_brake_free_run;
	reg         next_drag_correction;

	// Any nonzero gate value opens it, not only the value one
	function gate_is_open;
		input [7:0] gate;
		begin
			gate_is_open = (gate != 8'h00);
		end
	endfunction

	// Picks one control word bit so every decode line except keys_ok reads the same way
	function control_bit;
		input [15:0] word;
		input integer pos;
		begin
			control_bit = word[pos];
		end
	endfunction

	// Pin inputs pass two flip-flops before use
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			conn_meta <= 1'b0;
			conn_sync <= 1'b0;
			key_meta  <= 2'b00;
			key_sync  <= 2'b00;
		end else begin
			conn_meta <= bus_connected;
			conn_sync <= conn_meta;
			key_meta  <= {key_down, key_up};
			key_sync  <= key_meta;
		end
	end

	assign wr_ctl = wr_en && (index == `ADDR_RUN_CONTROL);
	assign wr_tgt = wr_en && (index == `ADDR_TARGET_POSITION);

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			control_write_gate <= `RST_CONTROL_WRITE_GATE;
			run_control        <= `RST_RUN_CONTROL;
			target_write_gate  <= `RST_TARGET_WRITE_GATE;
			target_position    <= `RST_TARGET_POSITION;
		end else if (wr_en) begin
			case (index)
			`ADDR_CONTROL_WRITE_GATE: control_write_gate <= wr_data[7:0];
			`ADDR_TARGET_WRITE_GATE:  target_write_gate  <= wr_data[7:0];
			default: begin
			end
			endcase
			// A closed gate swallows this write; the gate stays closed until software reopens it
			if (wr_ctl && ctl_gate_open)
				run_control <= wr_data[15:0];
			if (wr_tgt && tgt_gate_open)
				target_position <= wr_data;
		end
	end

	assign keys_ok = !conn_sync || run_control[`BIT_KEYS];
	assign key_jog = keys_ok && (key_sync[0] || key_sync[1]);

	assign ctl_gate_open = gate_is_open(control_write_gate);
	assign tgt_gate_open = gate_is_open(target_write_gate);
	assign pd_accept     = pd_target_valid && control_bit(run_control, `BIT_TRANSFER);

	always @* begin
		// New events win over the clear so none is lost
		next_error_status = error_status;
		if (control_bit(run_control, `BIT_CLEAR_ERR))
			next_error_status = 8'h00;
		next_error_status = next_error_status | error_events;
		next_run_up   = control_bit(run_control, `BIT_RUN_UP);
		next_run_down = control_bit(run_control, `BIT_RUN_DOWN);
		next_jog_up   = control_bit(run_control, `BIT_JOG_UP) || (keys_ok && key_sync[0]);
		next_jog_down = control_bit(run_control, `BIT_JOG_DOWN) || (keys_ok && key_sync[1]);
		next_jog_continuous = control_bit(run_control, `BIT_JOG_CONT);
		// Jog requests drive the axis even while the release bit is cleared
		next_axis_drive_enable = control_bit(run_control, `BIT_RELEASE) || control_bit(run_control, `BIT_JOG_UP) ||
			control_bit(run_control, `BIT_JOG_DOWN) || key_jog;
		next_position_start = pd_accept;
		// Process data takes priority; a gated register write only moves the goal otherwise
		next_position_goal = position_goal;
		if (pd_accept)
			next_position_goal = pd_target;
		else if (wr_tgt && tgt_gate_open)
			next_position_goal = wr_data;
		next_no_approach_loop = control_bit(run_control, `BIT_NO_LOOP);
		next_reference_loop   = control_bit(run_control, `BIT_REF_LOOP);
		next_readjust         = control_bit(run_control, `BIT_READJUST);
		next_brake_free_run   = control_bit(run_control, `BIT_BRAKE_FREE);
		next_drag_correction  = control_bit(run_control, `BIT_DRAG_CORR);
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			error_status      <= 8'h00;
			run_up            <= 1'b0;
			run_down          <= 1'b0;
			jog_up            <= 1'b0;
			jog_down          <= 1'b0;
			jog_continuous    <= 1'b0;
			axis_drive_enable <= 1'b0;
			position_start    <= 1'b0;
			position_goal     <= 32'h00000000;
			no_approach_loop  <= 1'b0;
			reference_loop    <= 1'b0;
			readjust          <= 1'b0;
			brake_free_run    <= 1'b0;
			drag_correction   <= 1'b0;
		end else begin
			error_status      <= next_error_status;
			run_up            <= next_run_up;
			run_down          <= next_run_down;
			jog_up            <= next_jog_up;
			jog_down          <= next_jog_down;
			jog_continuous    <= next_jog_continuous;
			axis_drive_enable <= next_axis_drive_enable;
			position_start    <= next_position_start;
			position_goal     <= next_position_goal;
			no_approach_loop  <= next_no_approach_loop;
			reference_loop    <= next_reference_loop;
			readjust          <= next_readjust;
			brake_free_run    <= next_brake_free_run;
			drag_correction   <= next_drag_correction;
		end
	end

	param_read_mux u_read (
		.clock              (clock),
		.rstn               (rstn),
		.rd_en              (rd_en),
		.rd_index           (index),
		.control_write_gate (control_write_gate),
		.run_control        (run_control),
		.target_write_gate  (target_write_gate),
		.target_position    (target_position),
		.rd_data            (rd_data),
		.rd_valid           (rd_valid),
		.rd_error           (rd_error)
	);
endmodule

/* File: run_command_checker_properties.sv */
// Port checker for the run-command parameter bank
`timescale 1ns/10ps
`include "run_command_defines.vh"
module run_command_checker (
	input logic        clock, rstn, wr_en, rd_en, rd_valid, rd_error, pd_target_valid, position_start,
	input logic        run_up, run_down, jog_continuous, axis_drive_enable, no_approach_loop,
	input logic        reference_loop, readjust, brake_free_run, drag_correction,
	input logic [7:0]  index, error_events, error_status,
	input logic [31:0] wr_data, rd_data, pd_target, position_goal
);
	logic [7:0]  gate;
	logic [15:0] cw, cq;
	wire         map = index >= `ADDR_CONTROL_WRITE_GATE && index <= `ADDR_TARGET_POSITION;
	// Shadow of the control word so decode checks see only accepted writes
	always_ff @(posedge clock or negedge rstn)
		if (!rstn) {gate, cw, cq} <= '0;
		else begin
			cq <= cw;
			if (wr_en && index == `ADDR_CONTROL_WRITE_GATE) gate <= wr_data[7:0];
			if (wr_en && index == `ADDR_RUN_CONTROL && gate != 8'h00) cw <= wr_data[15:0];
		end
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	a_read_answer: assert property (rd_en |=> rd_valid) else $error("read not answered");
	a_valid_alone: assert property (!rd_en |=> !rd_valid) else $error("spurious read valid");
	a_unmapped_err: assert property (rd_en && !map |=> rd_error && rd_data == 32'h0) else $error("bad unmapped read");
	a_mapped_ok: assert property (rd_en && map |=> !rd_error) else $error("mapped read flagged");
	a_word_decode: assert property ({run_up, run_down, jog_continuous, no_approach_loop, reference_loop,
		readjust, brake_free_run, drag_correction} == {cq[0], cq[1], cq[3], cq[6], cq[7], cq[10], cq[11], cq[12]})
		else $error("control word decode wrong");
	a_axis_release: assert property (|(cq & 16'h0310) |-> axis_drive_enable) else $error("axis idle");
	a_start_pos: assert property (pd_target_valid && cw[2] |=> position_start && position_goal == $past(pd_target))
		else $error("positioning not started");
	a_start_held: assert property (!(pd_target_valid && cw[2]) |=> !position_start) else $error("stray start");
	a_error_sticky: assert property (error_events != 0 |=> (error_status & $past(error_events)) == $past(error_events))
		else $error("error event lost");
	a_error_clear: assert property (cw[14] && error_events == 8'h00 |=> error_status == 8'h00) else $error("not cleared");
	c_unmapped: cover property (rd_error);
	c_start: cover property (position_start);
	c_clear: cover property (cw[14] && error_status != 8'h00);
endmodule
bind drive_run_command_registers run_command_checker i_chk (.clock, .rstn, .wr_en, .rd_en, .rd_valid, .rd_error,
	.pd_target_valid, .position_start, .run_up, .run_down, .jog_continuous, .axis_drive_enable, .no_approach_loop,
	.reference_loop, .readjust, .brake_free_run, .drag_correction, .index, .error_events, .error_status, .wr_data,
	.rd_data, .pd_target, .position_goal);

/* File: bus_master_model.sv */
// Field bus master model issuing one indexed parameter access at a time
`timescale 1ns/10ps
module bus_master_model (
	input  logic        clock,
	output logic        wr_en, rd_en,
	output logic [7:0]  index,
	output logic [31:0] wr_data
);
	initial {wr_en, rd_en, index, wr_data} = '0;
	// Released index and data lines show the inverse and both enables drop to zero so a stale value can never pass for a hold
	task automatic access(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge clock) #5 {wr_en, rd_en, index, wr_data} = {w, !w, i, d};
		@(posedge clock) #5 {wr_en, rd_en, index, wr_data} = {2'b00, ~i, ~d};
	endtask
endmodule

/* File: drive_run_command_registers_tb_top.sv */
// Self-checking bench for the run-command parameter bank
`timescale 1ns/10ps
`include "run_command_defines.vh"
module drive_run_command_registers_tb_top;
	logic        clock = 0, rstn = 0, pd_target_valid = 0, wr_en, rd_en, rd_valid, rd_error, position_start, axis_drive_enable;
	logic [7:0]  index, error_status, error_events = 0, ev;
	logic        bus_connected = 0, key_up = 0, key_down = 0, jog_up, jog_down;
	logic [31:0] wr_data, rd_data, position_goal, pd_target = 0, mdl [109:112];
	int          error_cnt, comparisons;
	always #50 clock = ~clock;
	bus_master_model i_master (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .index(index), .wr_data(wr_data));
	drive_run_command_registers i_drive_run_command_registers (.clock(clock), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en),
		.index(index), .wr_data(wr_data), .pd_target_valid(pd_target_valid), .pd_target(pd_target),
		.bus_connected(bus_connected), .key_up(key_up), .key_down(key_down), .error_events(error_events),
		.rd_data(rd_data), .rd_valid(rd_valid), .rd_error(rd_error), .error_status(error_status), .run_up(),
		.run_down(), .jog_up(jog_up), .jog_down(jog_down),
		.jog_continuous(), .axis_drive_enable(axis_drive_enable), .position_start(position_start),
		.position_goal(position_goal), .no_approach_loop(), .reference_loop(), .readjust(), .brake_free_run(),
		.drag_correction());
	task chk(input logic [32:0] got, input logic [32:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task wr(input logic [7:0] i, input logic [31:0] d);
		i_master.access(1, i, d);
		if (i == `ADDR_CONTROL_WRITE_GATE || i == `ADDR_TARGET_WRITE_GATE) mdl[i] = d[7:0];
		if (i == `ADDR_RUN_CONTROL && mdl[`ADDR_CONTROL_WRITE_GATE] != 0) mdl[i] = d[15:0];
		if (i == `ADDR_TARGET_POSITION && mdl[`ADDR_TARGET_WRITE_GATE] != 0) mdl[i] = d;
	endtask
	task rd(input logic [7:0] i);
		logic bad;
		bad = i < 8'h6d || i > 8'h70;
		i_master.access(0, i, 0);
		chk({rd_valid, rd_error}, {1'b1, bad}, "read flags");
		chk(rd_data, bad ? 32'h0 : mdl[i], "read data");
	endtask
	task pulse_target(input logic [31:0] t);
		pd_target = t;
		pd_target_valid = 1;
		@(posedge clock) #5 pd_target_valid = 0;
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#400000;
		error_cnt++;
		summarize();
	end
	initial begin
		void'($urandom(32'hcea9));
		mdl = '{default: 32'h0};
		repeat (10) @(posedge clock);
		#5 rstn = 1;
		for (int i = 8'h6c; i <= 8'h71; i++) rd(i);
		$display("test reset values done");
		wr(`ADDR_RUN_CONTROL, 32'h0010); rd(`ADDR_RUN_CONTROL);
		wr(`ADDR_TARGET_POSITION, $urandom); rd(`ADDR_TARGET_POSITION);
		wr(`ADDR_TARGET_WRITE_GATE, 8'h01); wr(`ADDR_TARGET_POSITION, $urandom); rd(`ADDR_TARGET_POSITION);
		wr(`ADDR_CONTROL_WRITE_GATE, 8'h80);
		for (int b = 0; b < 16; b++) begin
			wr(`ADDR_RUN_CONTROL, 32'h1 << b);
			@(posedge clock) #5 chk(axis_drive_enable, |(mdl[110] & 16'h0310), "axis drive");
		end
		$display("test control bits done");
		for (int k = 1; k >= 0; k--) begin
			wr(`ADDR_RUN_CONTROL, k << 2); pulse_target($urandom);
			chk(position_start, k, "position start");
			if (k) chk(position_goal, pd_target, "position goal");
		end
		ev = $urandom | 1; error_events = ev; @(posedge clock) #5 error_events = 0;
		chk(error_status, ev, "sticky errors");
		wr(`ADDR_RUN_CONTROL, 32'h4000); @(posedge clock) #5 chk(error_status, 0, "errors cleared");
		error_events = 8'h01; @(posedge clock) #5 error_events = 0;
		chk(error_status, 8'h01, "event beats clear");
		bus_connected = 1; key_up = 1; repeat (4) @(posedge clock);
		#5 chk({jog_up, jog_down, axis_drive_enable}, 3'b000, "keys locked");
		wr(`ADDR_RUN_CONTROL, 32'h4020); @(posedge clock) #5 chk({jog_up, jog_down, axis_drive_enable}, 3'b101, "keys on");
		wr(`ADDR_RUN_CONTROL, 32'h4200); @(posedge clock) #5 chk({jog_up, jog_down, axis_drive_enable}, 3'b011, "jog down");
		bus_connected = 0; key_up = 0;
		wr(`ADDR_CONTROL_WRITE_GATE, 8'h00); wr(`ADDR_RUN_CONTROL, 32'h0003); rd(`ADDR_RUN_CONTROL);
		$display("test process data and errors done");
		summarize();
	end
endmodule
